/* rtl/div_shift_pkg.sv */
// Purpose: Shared types and constants for the divide and shift datapath
// Assumes: 16-bit working registers, sixteen of them
// Notes:   Operation codes are binary coded
package div_shift_pkg;

  localparam int WORD_BITS    = 16;
  localparam int REG_ADDR_W   = 4;
  localparam int SHAMT_W      = 4;
  // One iteration per divisor bit
  localparam logic [4:0] DIV_ITER_COUNT = 5'h10;
  localparam logic [3:0] QUOT_REG_IDX   = 4'h0;
  localparam logic [3:0] REM_REG_IDX    = 4'h1;
  localparam logic [15:0] WORD_ZERO     = 16'h0000;
  localparam logic [31:0] DWORD_ZERO    = 32'h0000_0000;

  typedef enum logic [1:0] {
    arith_shift_right   = 2'b00,
    shift_left_op       = 2'b01,
    logical_shift_right = 2'b10
  } shift_kind_e;

  typedef enum logic [1:0] {
    DIV_IDLE = 2'b00,
    DIV_RUN  = 2'b01,
    DIV_FIX  = 2'b10,
    DIV_DONE = 2'b11
  } div_state_e;

  // Divide request from the decoder
  typedef struct packed {
    logic        isSigned;
    logic        isLong;
    logic [3:0]  divisorSel;
    logic [3:0]  dividendSel;
  } div_req_s;

  // Shift request from the decoder
  typedef struct packed {
    shift_kind_e kind;
    logic [3:0]  srcSel;
    logic [3:0]  dstSel;
    logic [3:0]  amount;
  } shift_req_s;

  // Register file write port
  typedef struct packed {
    logic        en;
    logic [3:0]  addr;
    logic [15:0] data;
  } reg_wr_s;

endpackage

/* rtl/divide_and_barrel_shift_unit.sv */
// Purpose: Iterative divider and single-cycle shifter of the core ALU
// Assumes: Decoder holds no second divide while busy is high
// Notes:   Three write ports, two for divide and one for shift; divide writes two registers
// Notes on behaviour
// - Divide 32/16 and 16/16, signed and unsigned.
// - Quotient goes to register zero, remainder to register one.
// - Divisor from any register; long dividend from aligned pair, high above.
// - One iteration per divisor bit; both sizes take equal cycles.
// - Single and multi-bit shifts complete in one cycle.
// - Right arithmetic or left shift up to 15 positions per cycle.
// - Shift source and destination are working registers only.
// - Arithmetic right shift moves toward the least significant bit.
// - Left shift moves toward the most significant bit.
// - Logical right shift moves toward the least significant bit.
`timescale 1ns/100ps
module divide_and_barrel_shift_unit
  import div_shift_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // Divide request
  input  wire logic                  divStart,
  input  wire div_req_s              divReq,
  // Shift request
  input  wire logic                  shiftStart,
  input  wire shift_req_s            shiftReq,
  // Register file read side
  input  wire logic [15:0]           regFile [16],
  // Results
  output logic                       divBusy,
  output logic                       divDone,
  output reg_wr_s                    divWrQuot,
  output reg_wr_s                    divWrRem,
  output reg_wr_s                    shiftWr
);

  div_state_e  state;
  logic [4:0]  iterCnt;
  logic [31:0] quot;
  logic [16:0] partRem;
  logic [15:0] divisorMag;
  logic        negQuot;
  logic        negRem;
  logic [31:0] dividendRaw;
  logic [31:0] dividendMag;
  logic [15:0] divisorRaw;
  logic [3:0]  pairBase;
  logic [16:0] trialSub;
  logic [16:0] shiftedRem;
  logic [15:0] shiftSrc;
  logic [15:0] next_shiftOut;

  // Aligned pair: even register low half, next odd register high half
  assign pairBase = {divReq.dividendSel[3:1], 1'b0};
  assign divisorRaw = regFile[divReq.divisorSel];

  always_comb
  begin
    if (divReq.isLong)
    begin
      dividendRaw = {regFile[pairBase + 4'h1], regFile[pairBase]};
    end
    else if (divReq.isSigned)
    begin
      dividendRaw = {{16{regFile[divReq.dividendSel][15]}},
                     regFile[divReq.dividendSel]};
    end
    else
    begin
      dividendRaw = {WORD_ZERO, regFile[divReq.dividendSel]};
    end
  end

  // Signed operands are reduced to magnitudes, sign applied at the end
  always_comb
  begin
    if (divReq.isSigned && dividendRaw[31])
    begin
      dividendMag = DWORD_ZERO - dividendRaw;
    end
    else
    begin
      dividendMag = dividendRaw;
    end
  end

  // One quotient bit per divisor bit; dividend upper half preloads
  // the partial remainder so that both sizes run sixteen steps
  assign shiftedRem = {partRem[15:0], quot[15]};
  assign trialSub   = shiftedRem - {1'b0, divisorMag};

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state      <= DIV_IDLE;
      iterCnt    <= 5'h00;
      quot       <= DWORD_ZERO;
      partRem    <= 17'h00000;
      divisorMag <= WORD_ZERO;
      negQuot    <= 1'b0;
      negRem     <= 1'b0;
    end
    else
    begin
      case (state)
        DIV_IDLE:
        begin
          if (divStart)
          begin
            state      <= DIV_RUN;
            iterCnt    <= DIV_ITER_COUNT;
            quot       <= {WORD_ZERO, dividendMag[15:0]};
            partRem    <= {1'b0, dividendMag[31:16]};
            divisorMag <= (divReq.isSigned && divisorRaw[15])
                          ? WORD_ZERO - divisorRaw : divisorRaw;
            negQuot    <= divReq.isSigned
                          && (dividendRaw[31] ^ divisorRaw[15]);
            negRem     <= divReq.isSigned && dividendRaw[31];
          end
        end
        DIV_RUN:
        begin
          if (!trialSub[16])
          begin
            partRem <= trialSub;
            quot    <= {quot[30:0], 1'b1};
          end
          else
          begin
            partRem <= shiftedRem;
            quot    <= {quot[30:0], 1'b0};
          end
          iterCnt <= iterCnt - 5'h01;
          if (iterCnt == 5'h01)
          begin
            state <= DIV_FIX;
          end
        end
        DIV_FIX:
        begin
          if (negQuot)
          begin
            quot[15:0] <= WORD_ZERO - quot[15:0];
          end
          if (negRem)
          begin
            partRem[15:0] <= WORD_ZERO - partRem[15:0];
          end
          state <= DIV_DONE;
        end
        DIV_DONE:
        begin
          state <= DIV_IDLE;
        end
        default:
        begin
          state <= DIV_IDLE;
        end
      endcase
    end
  end

  assign divBusy = (state != DIV_IDLE);
  assign divDone = (state == DIV_DONE);

  // Results always land in the fixed result registers
  always_comb
  begin
    divWrQuot.en   = divDone;
    divWrQuot.addr = QUOT_REG_IDX;
    divWrQuot.data = quot[15:0];
    divWrRem.en    = divDone;
    divWrRem.addr  = REM_REG_IDX;
    divWrRem.data  = partRem[15:0];
  end

  // Barrel shifter, register direct on both ends
  assign shiftSrc = regFile[shiftReq.srcSel];

  always_comb
  begin
    case (shiftReq.kind)
      arith_shift_right:
      begin
        next_shiftOut = $signed(shiftSrc) >>> shiftReq.amount;
      end
      shift_left_op:
      begin
        next_shiftOut = shiftSrc << shiftReq.amount;
      end
      logical_shift_right:
      begin
        next_shiftOut = shiftSrc >> shiftReq.amount;
      end
      default:
      begin
        next_shiftOut = shiftSrc;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shiftWr <= '0;
    end
    else
    begin
      shiftWr.en   <= shiftStart;
      shiftWr.addr <= shiftReq.dstSel;
      shiftWr.data <= next_shiftOut;
    end
  end

  // Checks
  sequence s_divLaunch;
    state == DIV_IDLE && divStart;
  endsequence

  sequence s_divFinish;
    ##18 divDone;
  endsequence

  property p_divLatency;
    @(posedge sys_clk) disable iff (!rst_n)
      s_divLaunch |-> s_divFinish;
  endproperty

  a_div_fixed_latency: assert property (p_divLatency)
    else $error("divide did not finish in fixed cycles");

  a_div_dest_regs: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
      divDone |-> divWrQuot.addr == 4'h0 && divWrRem.addr == 4'h1
                  && divWrQuot.en && divWrRem.en)
    else $error("divide result went to wrong registers");

  // Unsigned result must rebuild the dividend when no overflow can occur
  property p_divUnsigned;
    logic [31:0] dvdV;
    logic [15:0] dsV;
    @(posedge sys_clk) disable iff (!rst_n)
      (s_divLaunch ##0 (!divReq.isSigned && divisorRaw != WORD_ZERO
        && dividendRaw[31:16] < divisorRaw),
       dvdV = dividendRaw, dsV = divisorRaw)
      |-> ##18 ({WORD_ZERO, divWrQuot.data} * {WORD_ZERO, dsV}
                + {WORD_ZERO, divWrRem.data} == dvdV
                && divWrRem.data < dsV);
  endproperty

  a_div_unsigned_math: assert property (p_divUnsigned)
    else $error("unsigned divide check failed");

  a_div_busy_span: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
      s_divLaunch |=> divBusy [*8])
    else $error("divider dropped busy early");

  a_div_busy_drop: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
      divDone |=> !divBusy)
    else $error("divider stayed busy after done");

  a_shift_single_cycle: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
      shiftStart |=> shiftWr.en)
    else $error("shift result not written next cycle");

  a_shift_dest_reg: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
      shiftStart |=> shiftWr.addr == $past(shiftReq.dstSel))
    else $error("shift written to wrong register");

  a_asr_sign_fill: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
      shiftStart && shiftReq.kind == arith_shift_right
      && shiftReq.amount == 4'hf
      |=> shiftWr.data == {16{$past(shiftSrc[15])}})
    else $error("arithmetic shift did not fill sign");

  a_lsr_zero_fill: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
      shiftStart && shiftReq.kind == logical_shift_right
      |=> shiftWr.data == ($past(shiftSrc) >> $past(shiftReq.amount)))
    else $error("logical right shift wrong");

  a_sl_value: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
      shiftStart && shiftReq.kind == shift_left_op
      |=> shiftWr.data == 16'(($past(shiftSrc) << $past(shiftReq.amount))))
    else $error("left shift wrong");

  a_asr_value: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
      shiftStart && shiftReq.kind == arith_shift_right
      && shiftReq.amount == 4'h1
      |=> shiftWr.data == {$past(shiftSrc[15]), $past(shiftSrc[15:1])})
    else $error("arithmetic right shift by one wrong");

  a_div_signed_rem: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
      divDone && negRem && partRem[15:0] != 16'h0000
      |-> partRem[15])
    else $error("signed remainder sign wrong");

endmodule

/* tb/work_reg_model.sv */
// Purpose: Working register file that feeds the datapath
// Assumes: Bench loads operands through its own write port
// Notes:   Datapath results land here; a later port wins a clash
`timescale 1ns/100ps
module work_reg_model
  import div_shift_pkg::*;
(
  // Clock and reset
  input  wire logic    sys_clk,
  input  wire logic    rst_n,
  // Write ports
  input  wire reg_wr_s benchWr,
  input  wire reg_wr_s quotWr,
  input  wire reg_wr_s remWr,
  input  wire reg_wr_s shiftWr,
  // Read side
  output logic [15:0]  regs [16]
);
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 16; i++)
        regs[i] <= WORD_ZERO;
    end
    else
    begin
      if (benchWr.en)
        regs[benchWr.addr] <= benchWr.data;
      if (quotWr.en)
        regs[quotWr.addr] <= quotWr.data;
      if (remWr.en)
        regs[remWr.addr] <= remWr.data;
      if (shiftWr.en)
        regs[shiftWr.addr] <= shiftWr.data;
    end
  end
endmodule

/* tb/testbench.sv */
// Purpose: Self-checking bench for the divide and shift datapath
// Assumes: Divide answers 18 cycles after launch, shift one cycle after
// Notes:   Operands are kept in range so no quotient overflows
`timescale 1ns/100ps
module testbench
  import div_shift_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        divStart = 1'b0;
  logic        shiftStart = 1'b0;
  div_req_s    divReq = '0;
  shift_req_s  shiftReq = '0;
  reg_wr_s     benchWr = '0;
  logic [15:0] regs [16];
  logic        divBusy;
  logic        divDone;
  reg_wr_s     divWrQuot;
  reg_wr_s     divWrRem;
  reg_wr_s     shiftWr;
  int          mismatches = 0;
  int          numChecks = 0;
  int          cycles = 0;

  divide_and_barrel_shift_unit dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .divStart(divStart),
    .divReq(divReq), .shiftStart(shiftStart), .shiftReq(shiftReq),
    .regFile(regs), .divBusy(divBusy), .divDone(divDone),
    .divWrQuot(divWrQuot), .divWrRem(divWrRem), .shiftWr(shiftWr));
  work_reg_model regModel (
    .sys_clk(sys_clk), .rst_n(rst_n), .benchWr(benchWr),
    .quotWr(divWrQuot), .remWr(divWrRem), .shiftWr(shiftWr),
    .regs(regs));

  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic load(logic [3:0] a, logic [15:0] d);
    benchWr = '{1'b1, a, d};
    @(posedge sys_clk);
    #1;
  endtask

  function automatic logic [15:0] shift_exp(logic [1:0] k, logic [15:0] v,
                                            logic [3:0] a);
    case (k)
      2'b00: return $signed(v) >>> a;
      2'b01: return v << a;
      2'b10: return v >> a;
      default: return v;
    endcase
  endfunction

  task automatic do_shift(logic [1:0] k, logic [3:0] s, logic [3:0] d,
                          logic [3:0] a, logic [15:0] v);
    load(s, v);
    benchWr = '0;
    shiftReq = '{shift_kind_e'(k), s, d, a};
    shiftStart = 1'b1;
    @(posedge sys_clk);
    #1 shiftStart = 1'b0;
    check("shift en", shiftWr.en, 1'b1);
    check("shift addr", shiftWr.addr, d);
    check("shift data", shiftWr.data, shift_exp(k, v, a));
    // Let the result land before the next operand load can clash with it
    @(posedge sys_clk);
    #1 check("shift en drop", shiftWr.en, 1'b0);
    check("shift wb", regs[d], shift_exp(k, v, a));
  endtask

  task automatic do_div(logic sg, logic lg, logic [3:0] ds, logic [3:0] sel,
                        logic [31:0] dvd, logic [15:0] dv, bit poke);
    logic [31:0] q;
    logic [31:0] r;
    logic [31:0] dx;
    int          n;
    load({sel[3:1], 1'b1}, dvd[31:16]);
    load({sel[3:1], 1'b0}, dvd[15:0]);
    load(ds, dv);
    benchWr = '0;
    if (!lg)
      dvd = sg ? {{16{dvd[15]}}, dvd[15:0]} : {16'h0, dvd[15:0]};
    dx = sg ? {{16{dv[15]}}, dv} : {16'h0, dv};
    q = dvd / dx;
    r = dvd % dx;
    if (sg)
    begin
      q = $signed(dvd) / $signed(dx);
      r = $signed(dvd) % $signed(dx);
    end
    divReq = '{sg, lg, ds, sel};
    divStart = 1'b1;
    @(posedge sys_clk);
    #1 divStart = 1'b0;
    n = 0;
    while (divDone !== 1'b1 && n < 40)
    begin
      @(posedge sys_clk);
      #1 n++;
      // A launch while busy must be ignored
      if (poke)
        divStart = (n == 5);
      if (poke && n == 5)
        divReq = '1;
    end
    // Done shows once every step and the sign fix have run
    check("div cycles", n, DIV_ITER_COUNT + 1);
    check("quot en", {divWrQuot.en, divWrRem.en}, 2'b11);
    check("quot addr", divWrQuot.addr, QUOT_REG_IDX);
    check("rem addr", divWrRem.addr, REM_REG_IDX);
    check("quotient", divWrQuot.data, q[15:0]);
    check("remainder", divWrRem.data, r[15:0]);
    @(posedge sys_clk);
    #1 check("busy after", divBusy, 1'b0);
  endtask

  initial
  begin
    logic [31:0] x;
    logic [15:0] mag;
    logic [3:0]  b;
    void'($urandom(32'h94c0));
    repeat (5) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    // Full-range amounts, sign fill and zero fill
    do_shift(2'b00, 4'h3, 4'h9, 4'hf, 16'h8001);
    do_shift(2'b01, 4'h3, 4'h9, 4'hf, 16'h0003);
    do_shift(2'b10, 4'h3, 4'h9, 4'hf, 16'h8000);
    do_shift(2'b00, 4'h5, 4'h5, 4'h1, 16'hfffe);
    do_shift(2'b11, 4'h2, 4'h7, 4'h4, 16'h1234);
    repeat (60)
      do_shift(2'($urandom % 3), 4'($urandom), 4'($urandom),
               4'($urandom), 16'($urandom));
    // Small divisors, negative operands
    do_div(1'b1, 1'b0, 4'h4, 4'h6, 32'h0000_fff9, 16'h0002, 1'b0);
    do_div(1'b0, 1'b0, 4'h4, 4'h6, 32'h0000_fff9, 16'h0002, 1'b0);
    do_div(1'b1, 1'b1, 4'h0, 4'h3, 32'hfffe_7960, 16'hfff9, 1'b1);
    // Reset in mid divide clears busy and every write port
    divReq = '{1'b0, 1'b0, 4'h4, 4'h6};
    divStart = 1'b1;
    @(posedge sys_clk);
    #1 divStart = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 rst_n = 1'b0;
    #1 check("busy in reset", divBusy, 1'b0);
    check("done in reset", {divDone, divWrQuot.en, divWrRem.en}, 3'h0);
    check("shift en in reset", shiftWr.en, 1'b0);
    @(posedge sys_clk);
    #1 rst_n = 1'b1;
    do_div(1'b0, 1'b1, 4'h8, 4'ha, 32'h0003_1234, 16'h8001, 1'b0);
    for (int i = 0; i < 40; i++)
    begin
      b = 4'(2 * ($urandom % 7) + 2);
      mag = 16'h4000 | (16'($urandom) & 16'h3fff);
      x = $urandom;
      x = {{3{x[28]}}, x[28:0]};
      if (!i[0])
        x[31:29] = 3'h0;
      do_div(i[0], i[1], b - 4'h2, b | {3'h0, i[2] & i[1]}, x,
             x[30] ? -mag : mag, 1'b0);
    end
    stop_test();
  end
endmodule
